// file: rtl/brr_pkg.sv
// Shared constants, register map and helper function of the rotate unit.
package brr_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_SRC_A_LO = 8'h04;
   localparam logic [7:0] OFF_SRC_A_HI = 8'h08;
   localparam logic [7:0] OFF_SRC_B_LO = 8'h0c;
   localparam logic [7:0] OFF_SRC_B_HI = 8'h10;
   localparam logic [7:0] OFF_CMD = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_RESULT_LO = 8'h1c;
   localparam logic [7:0] OFF_RESULT_HI = 8'h20;
   localparam logic [7:0] OFF_FLAGS = 8'h24;

   ////////////////////////////////////////////////////////////////////////////
   // Control register fields.
   localparam int unsigned CTRL_OP_LSB = 0;
   localparam int unsigned CTRL_WIDTH_BIT = 4;
   localparam int unsigned CTRL_CODE_LSB = 5;
   localparam int unsigned CTRL_SIZE_BIT = 7;
   localparam int unsigned CTRL_AMT_LSB = 8;
   localparam int unsigned CTRL_MASK_LSB = 16;
   localparam int unsigned CTRL_FLAGM_BIT = 24;
   localparam logic [31:0] CTRL_RESET = 32'h0100_0000;
   localparam logic [31:0] CTRL_USED = 32'h010f_3ff3;

   localparam int unsigned CMD_START_BIT = 0;
   localparam int unsigned STATUS_DONE_BIT = 0;
   localparam int unsigned STATUS_UNDEF_BIT = 1;

   // Flag positions inside the four-bit condition flag word.
   localparam int unsigned FLAG_N = 3;
   localparam int unsigned FLAG_Z = 2;
   localparam int unsigned FLAG_C = 1;
   localparam int unsigned FLAG_V = 0;
   localparam logic [3:0] FLAGS_RESET = 4'h0;

   localparam logic [1:0] CODE_FULL = 2'h3;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   typedef enum logic [1:0]
   {
      OP_BYTE_REVERSE,
      OP_ROTATE_IMM,
      OP_ROTATE_VAR,
      OP_ROTATE_FLAGS
   } brr_op_t;

   // Merges write data into a register under the APB byte strobes.
   function automatic logic [31:0] brr_merge(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = wdata[i*8 +: 8];
         end
      end
      return res;
   endfunction

endpackage

// file: rtl/brr_byte_rev.sv
// Byte reversal inside containers of 8, 16, 32 or 64 bits.
`timescale 1ns/10ps
module brr_byte_rev
(
   input wire logic [63:0] data,
   input wire logic wide,
   input wire logic [1:0] code,
   output logic [63:0] result
);

   logic [2:0] flip;

   always_comb
   begin
      // Container of 8 << code bits: byte index is flipped in its low bits.
      flip = 3'((4'h1 << code) - 4'h1);
      result = 64'h0;
      for (int i = 0; i < 8; i++)
      begin
         // A 32-bit form zeroes the top and reads only the low word unless code is 11.
         if (wide || i < 4)
         begin
            result[i*8 +: 8] = data[(3'(i) ^ flip)*8 +: 8];
         end
      end
   end

endmodule

// file: rtl/brr_rotate.sv
// Rotate right of a 64-bit or 32-bit operand by a given amount.
`timescale 1ns/10ps
module brr_rotate
(
   input wire logic [63:0] data,
   input wire logic [5:0] amount,
   input wire logic wide,
   output logic [63:0] result
);

   logic [127:0] doubled;
   logic [63:0] narrow;

   always_comb
   begin
      // Doubling the operand brings shifted-out bits back in at the top.
      doubled = {data, data} >> amount;
      narrow = {data[31:0], data[31:0]} >> amount[4:0];
      if (wide)
      begin
         result = doubled[63:0];
      end
      else
      begin
         result = {32'h0, narrow[31:0]};
      end
   end

endmodule

// file: rtl/brr_top.sv
// APB-attached byte-reverse and rotate datapath with flag insertion.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module brr_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [3:0] flags,
   output logic exec_done,
   output logic exec_undefined
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state.
   logic [31:0] ctrl_reg;
   logic [31:0] src_a_lo_reg;
   logic [31:0] src_a_hi_reg;
   logic [31:0] src_b_lo_reg;
   logic [31:0] src_b_hi_reg;
   logic [63:0] result_reg;
   logic [3:0] flags_reg;
   logic done_reg;
   logic undef_reg;
   logic [31:0] prdata_reg;

   logic [31:0] prdata_next;
   logic [63:0] result_next;
   logic [3:0] flags_next;
   logic undef_next;

   logic setup, access, wr_en, mapped, start, status_clear;

   brr_pkg::brr_op_t op;
   logic wide;
   logic [1:0] code;
   logic size_bit;
   logic [5:0] amt_field;
   logic [3:0] mask;
   logic flagm_en;
   logic [63:0] src_a;
   logic [63:0] src_b;
   logic [63:0] rev_res;
   logic [63:0] rot_res;
   logic [5:0] rot_amt;
   logic rot_wide;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   always_comb
   begin
      unique case (paddr)
         brr_pkg::OFF_CTRL,
         brr_pkg::OFF_SRC_A_LO,
         brr_pkg::OFF_SRC_A_HI,
         brr_pkg::OFF_SRC_B_LO,
         brr_pkg::OFF_SRC_B_HI,
         brr_pkg::OFF_CMD,
         brr_pkg::OFF_STATUS,
         brr_pkg::OFF_RESULT_LO,
         brr_pkg::OFF_RESULT_HI,
         brr_pkg::OFF_FLAGS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // The slave never stalls, so every transfer ends in its first access.
   assign pready = 1'b1;
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign pslverr = access && !mapped;
   assign wr_en = access && pwrite && mapped;
   assign start = wr_en && paddr == brr_pkg::OFF_CMD && pstrb[0]
                  && pwdata[brr_pkg::CMD_START_BIT];
   assign status_clear = wr_en && paddr == brr_pkg::OFF_STATUS && pstrb[0];

   ////////////////////////////////////////////////////////////////////////////
   // Software-written registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= brr_pkg::CTRL_RESET;
      end
      else if (wr_en && paddr == brr_pkg::OFF_CTRL)
      begin
         ctrl_reg <= brr_pkg::brr_merge(ctrl_reg, pwdata, pstrb)
                     & brr_pkg::CTRL_USED;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_a_lo_reg <= brr_pkg::WORD_RESET;
         src_a_hi_reg <= brr_pkg::WORD_RESET;
         src_b_lo_reg <= brr_pkg::WORD_RESET;
         src_b_hi_reg <= brr_pkg::WORD_RESET;
      end
      else if (wr_en)
      begin
         unique case (paddr)
            brr_pkg::OFF_SRC_A_LO:
               src_a_lo_reg <= brr_pkg::brr_merge(src_a_lo_reg, pwdata, pstrb);
            brr_pkg::OFF_SRC_A_HI:
               src_a_hi_reg <= brr_pkg::brr_merge(src_a_hi_reg, pwdata, pstrb);
            brr_pkg::OFF_SRC_B_LO:
               src_b_lo_reg <= brr_pkg::brr_merge(src_b_lo_reg, pwdata, pstrb);
            brr_pkg::OFF_SRC_B_HI:
               src_b_hi_reg <= brr_pkg::brr_merge(src_b_hi_reg, pwdata, pstrb);
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Operand and control field extraction.
   assign op = brr_pkg::brr_op_t'(ctrl_reg[brr_pkg::CTRL_OP_LSB +: 2]);
   assign wide = ctrl_reg[brr_pkg::CTRL_WIDTH_BIT];
   assign code = ctrl_reg[brr_pkg::CTRL_CODE_LSB +: 2];
   assign size_bit = ctrl_reg[brr_pkg::CTRL_SIZE_BIT];
   assign amt_field = ctrl_reg[brr_pkg::CTRL_AMT_LSB +: 6];
   assign mask = ctrl_reg[brr_pkg::CTRL_MASK_LSB +: 4];
   assign flagm_en = ctrl_reg[brr_pkg::CTRL_FLAGM_BIT];
   assign src_a = {src_a_hi_reg, src_a_lo_reg};
   assign src_b = {src_b_hi_reg, src_b_lo_reg};

   // Width 1 with code 10 reverses each word; code 11 reverses all bytes.
   brr_byte_rev u_rev
   (
      .data(src_a),
      .wide(wide),
      .code(code),
      .result(rev_res)
   );

   brr_rotate u_rot
   (
      .data(src_a),
      .amount(rot_amt),
      .wide(rot_wide),
      .result(rot_res)
   );

   always_comb
   begin
      rot_wide = wide;
      rot_amt = amt_field;
      unique case (op)
         brr_pkg::OP_ROTATE_VAR:
         begin
            // Low bits of the amount register are the remainder by width.
            rot_amt = wide ? src_b[5:0]
                           : {1'b0, src_b[4:0]};
         end
         brr_pkg::OP_ROTATE_IMM:
         begin
            // Same source feeds both halves of the extract.
            rot_amt = wide ? amt_field
                           : {1'b0, amt_field[4:0]};
         end
         brr_pkg::OP_ROTATE_FLAGS:
         begin
            rot_wide = 1'b1;
            rot_amt = amt_field;
         end
         brr_pkg::OP_BYTE_REVERSE: rot_amt = amt_field;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Execution: every operation finishes in the same single cycle.
   always_comb
   begin
      result_next = result_reg;
      flags_next = flags_reg;
      undef_next = 1'b0;
      unique case (op)
         brr_pkg::OP_BYTE_REVERSE:
         begin
            if (!wide && code == brr_pkg::CODE_FULL)
            begin
               undef_next = 1'b1;
            end
            else
            begin
               result_next = rev_res;
            end
         end
         brr_pkg::OP_ROTATE_IMM:
         begin
            if ((!wide && !size_bit && !amt_field[5])
                || (wide && size_bit))
            begin
               result_next = rot_res;
            end
            else
            begin
               undef_next = 1'b1;
            end
         end
         brr_pkg::OP_ROTATE_VAR: result_next = rot_res;
         brr_pkg::OP_ROTATE_FLAGS:
         begin
            if (!flagm_en)
            begin
               undef_next = 1'b1;
            end
            else
            begin
               for (int i = 0; i < 4; i++)
               begin
                  if (mask[i])
                  begin
                     flags_next[i] = rot_res[i];
                  end
               end
            end
         end
      endcase
   end

   // The cycle count is fixed and no path waits on operand values.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         result_reg <= 64'h0;
      end
      else if (start)
      begin
         result_reg <= result_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flags_reg <= brr_pkg::FLAGS_RESET;
      end
      else if (start)
      begin
         flags_reg <= flags_next;
      end
      else if (wr_en && paddr == brr_pkg::OFF_FLAGS && pstrb[0])
      begin
         flags_reg <= pwdata[3:0];
      end
   end

   // A start in the same cycle as a clear wins, so no completion is lost.
   // Nothing here can be aborted midway, so exceptions see no data effect.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         done_reg <= 1'b0;
         undef_reg <= 1'b0;
      end
      else if (start)
      begin
         done_reg <= 1'b1;
         undef_reg <= undef_next;
      end
      else if (status_clear)
      begin
         done_reg <= done_reg & ~pwdata[brr_pkg::STATUS_DONE_BIT];
         undef_reg <= undef_reg & ~pwdata[brr_pkg::STATUS_UNDEF_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path, captured in the setup cycle so data stands for the access.
   always_comb
   begin
      unique case (paddr)
         brr_pkg::OFF_CTRL: prdata_next = ctrl_reg;
         brr_pkg::OFF_SRC_A_LO: prdata_next = src_a_lo_reg;
         brr_pkg::OFF_SRC_A_HI: prdata_next = src_a_hi_reg;
         brr_pkg::OFF_SRC_B_LO: prdata_next = src_b_lo_reg;
         brr_pkg::OFF_SRC_B_HI: prdata_next = src_b_hi_reg;
         brr_pkg::OFF_STATUS: prdata_next = {30'h0, undef_reg, done_reg};
         brr_pkg::OFF_RESULT_LO: prdata_next = result_reg[31:0];
         brr_pkg::OFF_RESULT_HI: prdata_next = result_reg[63:32];
         brr_pkg::OFF_FLAGS: prdata_next = {28'h0, flags_reg};
         default: prdata_next = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg <= 32'h0;
      end
      else if (setup && !pwrite)
      begin
         prdata_reg <= prdata_next;
      end
   end

   assign prdata = prdata_reg;
   assign flags = flags_reg;
   assign exec_done = done_reg;
   assign exec_undefined = undef_reg;

endmodule

// file: tb/brr_top_sva.sv
// Assertion checker for the bus and status ports of the rotate unit.
`timescale 1ns/10ps
module brr_top_sva
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] flags,
   input wire logic exec_done,
   input wire logic exec_undefined
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   wire acc = psel & penable;
   wire wr = acc & pwrite & pstrb[0];
   wire start = wr & (paddr == brr_pkg::OFF_CMD) & pwdata[0];
   wire stclr = wr & (paddr == brr_pkg::OFF_STATUS);
   wire clr0 = stclr & pwdata[0];
   wire upd = start | (wr & (paddr == brr_pkg::OFF_FLAGS));
   wire ust = start | stclr;
   wire rs = psel & ~penable & ~pwrite;
   wire mapped = (paddr[1:0] == 2'h0) && (paddr <= brr_pkg::OFF_FLAGS);
   ////////////////////////////////////////////////////////////
   property p_ready;
      acc |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("wait state seen");
   property p_err;
      acc && !mapped |-> pslverr;
   endproperty
   a_err: assert property (p_err) else $error("unmapped not refused");
   property p_ok;
      acc && mapped |-> !pslverr;
   endproperty
   a_ok: assert property (p_ok) else $error("mapped access refused");
   property p_done;
      start |=> exec_done;
   endproperty
   a_done: assert property (p_done) else $error("done late");
   // An undefined operation must leave the flags exactly as they were.
   property p_undef_flags;
      start ##1 exec_undefined |-> flags == $past(flags);
   endproperty
   a_undef_flags: assert property (p_undef_flags)
      else $error("flags moved on undefined");
   property p_flags_src;
      $changed(flags) |-> $past(upd);
   endproperty
   a_flags_src: assert property (p_flags_src)
      else $error("flags changed without cause");
   property p_sticky;
      exec_done && !stclr |=> exec_done;
   endproperty
   a_sticky: assert property (p_sticky) else $error("done dropped");
   property p_clear;
      clr0 |=> !exec_done;
   endproperty
   a_clear: assert property (p_clear) else $error("done not cleared");
   property p_undef_hold;
      $changed(exec_undefined) |-> $past(ust);
   endproperty
   a_undef_hold: assert property (p_undef_hold)
      else $error("undefined flag moved");
   property p_prdata;
      $changed(prdata) |-> $past(rs);
   endproperty
   a_prdata: assert property (p_prdata) else $error("read data moved");
   c_start: cover property (start);
   c_undef: cover property (start ##1 exec_undefined);
   c_err: cover property (acc && pslverr);
endmodule
bind brr_top brr_top_sva u_sva
(
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .flags(flags),
   .exec_done(exec_done), .exec_undefined(exec_undefined)
);

// file: tb/brr_apb_master.sv
// Bus master model that drives the register port of the rotate unit.
`timescale 1ns/10ps
module brr_apb_master
(
   input wire logic pclk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hf;
   end
   ////////////////////////////////////////////////////////////
   // Write data is inverted once released, so a late sampler sees junk.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
endmodule

// file: tb/brr_top_test.sv
// Self-checking testbench of the byte-reverse and rotate unit.
`timescale 1ns/10ps
module brr_top_test;
   typedef struct {logic [31:0] c; logic [63:0] a, b, r; logic [3:0] f;}
      brr_row_t;
   localparam logic [63:0] sa = 64'h0123_4567_89ab_cdef;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr;
   logic exec_done, exec_undefined;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, flags;
   int n_mismatch = 0;
   int n_checks = 0;
   brr_row_t rows[12] = '{
      '{32'h0100_0050, sa, 64'h0, 64'h6745_2301_efcd_ab89, 4'h5},
      '{32'h0100_0070, sa, 64'h0, 64'hefcd_ab89_6745_2301, 4'h5},
      '{32'h0100_0010, sa, 64'h0, sa, 4'h5},
      '{32'h0100_0030, sa, 64'h0, 64'h2301_6745_ab89_efcd, 4'h5},
      '{32'h0100_0040, sa, 64'h0, 64'h0000_0000_efcd_ab89, 4'h5},
      '{32'h0100_0401, sa, 64'h0, 64'h0000_0000_f89a_bcde, 4'h5},
      '{32'h0100_0891, sa, 64'h0, 64'hef01_2345_6789_abcd, 4'h5},
      '{32'h0100_0002, sa, 64'hffff_ffff_ffff_ffe4,
        64'h0000_0000_f89a_bcde, 4'h5},
      '{32'h0100_0012, sa, 64'hffff_ffff_ffff_ffc8,
        64'hef01_2345_6789_abcd, 4'h5},
      '{32'h010a_0403, sa, 64'h0, 64'h0, 4'hf},
      '{32'h010f_3f03, sa, 64'h0, 64'h0, 4'he},
      '{32'h0108_0003, sa, 64'h0, 64'h0, 4'hd}};
   logic [31:0] bad[4] = '{32'h0100_0060, 32'h0100_2001,
                           32'h0100_0011, 32'h000f_0003};
   brr_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .flags(flags),
      .exec_done(exec_done), .exec_undefined(exec_undefined));
   brr_apb_master m (.pclk(pclk), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
   always #2 pclk = ~pclk;
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      m.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic e);
      m.xfer(1'b0, a, 32'h0, d, e);
   endtask
   task automatic res(output logic [63:0] r);
      logic [31:0] lo, hi;
      logic e;
      rd(brr_pkg::OFF_RESULT_LO, lo, e);
      rd(brr_pkg::OFF_RESULT_HI, hi, e);
      r = {hi, lo};
   endtask
   task automatic op(input logic [31:0] c, input logic [63:0] a,
                     input logic [63:0] b);
      wr(brr_pkg::OFF_FLAGS, 32'h5);
      wr(brr_pkg::OFF_SRC_A_LO, a[31:0]);
      wr(brr_pkg::OFF_SRC_A_HI, a[63:32]);
      wr(brr_pkg::OFF_SRC_B_LO, b[31:0]);
      wr(brr_pkg::OFF_SRC_B_HI, b[63:32]);
      wr(brr_pkg::OFF_CTRL, c);
      wr(brr_pkg::OFF_CMD, 32'h1);
      @(negedge pclk);
   endtask
   task automatic rst_chk;
      logic [63:0] r;
      logic [31:0] d;
      logic e;
      @(negedge pclk);
      chk(64'(flags), 64'h0);
      chk(64'(exec_done), 64'h0);
      chk(64'(exec_undefined), 64'h0);
      chk(64'(prdata), 64'h0);
      rd(brr_pkg::OFF_CTRL, d, e);
      chk(64'(d), 64'(brr_pkg::CTRL_RESET));
      res(r);
      chk(r, 64'h0);
      $display("reset test done");
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge pclk);
      n_mismatch++;
      print_verdict;
   end
   initial
   begin
      logic [63:0] r, q;
      logic [31:0] d;
      logic e;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rst_chk;
      foreach (rows[i])
      begin
         op(rows[i].c, rows[i].a, rows[i].b);
         chk(64'(flags), 64'(rows[i].f));
         chk(64'({exec_done, exec_undefined}), 64'h2);
         if (rows[i].c[1:0] != 2'h3)
         begin
            res(r);
            chk(r, rows[i].r);
         end
         $display("row %0d done", i);
      end
      res(r);
      foreach (bad[i])
      begin
         op(bad[i], sa, 64'h0);
         chk(64'({exec_undefined, flags}), 64'h15);
         res(q);
         chk(q, r);
      end
      $display("undefined test done");
      wr(brr_pkg::OFF_STATUS, 32'h3);
      @(negedge pclk);
      chk(64'({exec_done, exec_undefined}), 64'h0);
      rd(8'h28, d, e);
      chk(64'({e, d}), 64'h1_0000_0000);
      rd(brr_pkg::OFF_CMD, d, e);
      chk(64'({e, d}), 64'h0);
      wr(brr_pkg::OFF_CTRL, 32'hffff_ffff);
      rd(brr_pkg::OFF_CTRL, d, e);
      chk(64'(d), 64'(brr_pkg::CTRL_USED));
      $display("status and map test done");
      op(bad[0], sa, 64'h0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rst_chk;
      print_verdict;
   end
endmodule
